// ===== sim/vendor_feature_control_tb.sv
module vendor_feature_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk_in = 1'b0, rst_b_in = 1'b0;
  vfc_pkg::reg_req_type     reg_req_in = '0;
  logic [31:0]              reg_rdata_out, q, prom_load_data_in = '0;
  logic                     prom_load_valid_in = 1'b0, link_rate_wr_in = 1'b0;
  logic                     host_phy_program_in = 1'b0, cycle_lost_in = 1'b0;
  logic                     host_phy_enhance_in = 1'b0, cycle_seen_in = 1'b0;
  logic                     nand_tree_in = 1'b0, bist_status_in = 1'b1;
  logic [2:0]               link_rate_wdata_in = 3'h5, link_rate_field_out;
  logic                     reg_rvalid_out, host_bits_wr_out, prom_tick_out;
  logic                     host_program_wr_out, host_enhance_wr_out;
  logic                     no_cycle_master_out, test_output_pin_out;
  logic                     bus_holder_en_out, pm_visible_out;
  vfc_pkg::phy_feature_type phy_feature_out;
  int                       miscompares = 0, n_tests = 0, i, k, n;
  // Row: mode, enhance, modifier, result
  logic [4:0] rows [16] = '{5'b00000, 5'b00101, 5'b00011, 5'b00110,
    5'b01000, 5'b01100, 5'b01010, 5'b01111, 5'b10000, 5'b10101,
    5'b10011, 5'b10111, 5'b11000, 5'b11101, 5'b11011, 5'b11110};

  always #2.5 clk_in = ~clk_in;

  // Short tick dividers keep the rate checks brief
  vendor_feature_control #(.PROM_DIV_NORMAL(8), .PROM_DIV_FAST(2)) dut (
    .clk_in, .rst_b_in, .reg_req_in, .reg_rdata_out, .reg_rvalid_out,
    .prom_load_valid_in, .prom_load_data_in, .host_phy_program_in,
    .host_phy_enhance_in, .host_bits_wr_out, .host_program_wr_out,
    .host_enhance_wr_out, .link_rate_wr_in, .link_rate_wdata_in,
    .link_rate_field_out, .cycle_lost_in, .cycle_seen_in,
    .no_cycle_master_out, .nand_tree_in, .bist_status_in,
    .test_output_pin_out, .bus_holder_en_out, .pm_visible_out,
    .prom_tick_out, .phy_feature_out);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_in);
    reg_req_in = '{1'b1, 1'b0, a, 4'hF, d};
    @(negedge clk_in);
    reg_req_in = '0;
    repeat (2) @(negedge clk_in);
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge clk_in);
    reg_req_in = '{1'b0, 1'b1, a, 4'hF, 32'h0000_0000};
    @(negedge clk_in);
    reg_req_in = '0;
    for (k = 0; k < 4 && reg_rvalid_out !== 1'b1; k++) @(negedge clk_in);
    if (k == 4) begin
      miscompares++;
      give_verdict();
    end
    q = reg_rdata_out;
  endtask

  task automatic pulse(ref logic s, input int c);
    repeat (c) begin
      @(negedge clk_in);
      s = 1'b1;
      @(negedge clk_in);
      s = 1'b0;
    end
    repeat (2) @(negedge clk_in);
  endtask

  task automatic ticks(input int c);
    n = 0;
    repeat (c) begin
      @(negedge clk_in);
      n += int'(prom_tick_out);
    end
  endtask

  initial begin
    repeat (10) @(negedge clk_in);
    rst_b_in = 1'b1;
    rd(8'h00);
    chk(q, 32'h0000_0000);
    for (i = 0; i < 16; i++) begin
      host_phy_enhance_in = rows[i][2];
      wr(8'h00, {14'h0000, rows[i][4:3], 6'h00, rows[i][1], 1'b0,
                 {3{rows[i][1]}}, 5'h00});
      chk(phy_feature_out, {4{rows[i][0]}});
    end
    host_phy_enhance_in = 1'b0;
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00);
    chk(q, 32'h003F_1EE0);
    chk({bus_holder_en_out, pm_visible_out, test_output_pin_out}, 3'h7);
    chk(no_cycle_master_out, 1'b1);
    pulse(link_rate_wr_in, 1);
    chk(link_rate_field_out, 3'h0);
    ticks(20);
    chk(n, 10);
    host_phy_program_in = 1'b1;
    wr(8'h00, 32'h0000_0000);
    ticks(40);
    chk(n, 5);
    chk(test_output_pin_out, 1'b0);
    rd(8'h00);
    chk(q, 32'h0000_4000);
    pulse(link_rate_wr_in, 1);
    chk(link_rate_field_out, 3'h5);
    wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h04);
    chk(q, 32'h0000_0000);
    pulse(cycle_lost_in, 254);
    chk(no_cycle_master_out, 1'b0);
    pulse(cycle_lost_in, 1);
    chk(no_cycle_master_out, 1'b1);
    pulse(cycle_seen_in, 1);
    chk(no_cycle_master_out, 1'b0);
    wr(8'h00, 32'h0000_0800);
    pulse(cycle_lost_in, 255);
    chk(no_cycle_master_out, 1'b0);
    @(negedge clk_in);
    reg_req_in = '{1'b1, 1'b0, 8'h00, 4'h2, 32'h0000_2000};
    @(negedge clk_in);
    reg_req_in = '0;
    chk({host_bits_wr_out, host_program_wr_out, host_enhance_wr_out},
        3'h5);
    prom_load_data_in = 32'h0020_0000;
    pulse(prom_load_valid_in, 1);
    chk(bus_holder_en_out, 1'b1);
    rst_b_in = 1'b0;
    @(negedge clk_in);
    chk(bus_holder_en_out, 1'b0);
    rst_b_in = 1'b1;
    rd(8'h00);
    chk(q, 32'h0000_4000);
    give_verdict();
  end
endmodule // vendor_feature_control_tb

// ===== sim/vfc_monitor.sv
module vfc_monitor (
  input  wire logic                 clk_in,              // Clock
  input  wire logic                 rst_b_in,            // Reset
  input  wire vfc_pkg::reg_req_type reg_req_in,          // Bus request
  input  wire logic                 prom_load_valid_in,  // Load strobe
  input  wire logic [31:0]          prom_load_data_in,   // Load word
  input  wire logic [31:0]          reg_rdata_out,       // Read data
  input  wire logic                 reg_rvalid_out,      // Read done
  input  wire logic                 host_bits_wr_out,    // Mirror write
  input  wire logic                 host_program_wr_out, // New bit 23
  input  wire logic                 bus_holder_en_out,   // Holders
  input  wire logic                 no_cycle_master_out  // Absent
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // Load is excluded: it outranks a write in the same cycle
  sequence s_ctrl_wr;
    reg_req_in.wr_en && reg_req_in.addr == 8'h00 && !prom_load_valid_in;
  endsequence

  a_holder_follow: assert property (
    s_ctrl_wr ##0 reg_req_in.be[2] |->
      ##2 bus_holder_en_out == $past(reg_req_in.wdata[21], 2))
    else $error("holder output does not follow write");
  a_holder_cause: assert property (
    $changed(bus_holder_en_out) |->
      $past(reg_req_in.wr_en, 2) || $past(prom_load_valid_in, 2))
    else $error("holder output changed without cause");
  a_mirror_fwd: assert property (
    s_ctrl_wr ##0 reg_req_in.be[1] |=> host_bits_wr_out &&
      host_program_wr_out == $past(reg_req_in.wdata[14]))
    else $error("host bit write not forwarded");
  a_force_absent: assert property (
    s_ctrl_wr ##0 reg_req_in.be[1] && reg_req_in.wdata[10] |->
      ##2 no_cycle_master_out)
    else $error("forced absent master not shown");
  a_prom_load: assert property (
    prom_load_valid_in |->
      ##2 bus_holder_en_out == $past(prom_load_data_in[21], 2))
    else $error("load word not applied");
  a_read_answer: assert property (
    reg_req_in.rd_en |=> reg_rvalid_out)
    else $error("read not answered");
  a_reserved_zero: assert property (
    reg_rvalid_out |-> reg_rdata_out[31:22] == 10'h000 &&
      !reg_rdata_out[8] && !reg_rdata_out[4])
    else $error("reserved bits not zero");
  a_unmapped_zero: assert property (
    reg_rvalid_out && $past(reg_req_in.addr) != 8'h00 |->
      reg_rdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule // vfc_monitor

bind vendor_feature_control vfc_monitor u_mon (
  .clk_in, .rst_b_in, .reg_req_in, .prom_load_valid_in, .prom_load_data_in,
  .reg_rdata_out, .reg_rvalid_out, .host_bits_wr_out, .host_program_wr_out,
  .bus_holder_en_out, .no_cycle_master_out
);

// ===== src/vendor_feature_control.sv
module vendor_feature_control #(
  parameter int         PROM_DIV_NORMAL = 500,
  parameter int         PROM_DIV_FAST   = 25,
  parameter logic [2:0] LINK_RATE_RESET = 3'h0
) (
  input  wire logic                     clk_in,               // 200 MHz
  input  wire logic                     rst_b_in,             // Async reset
  input  wire vfc_pkg::reg_req_type     reg_req_in,           // Reg access
  output logic [31:0]                   reg_rdata_out,        // Read data
  output logic                          reg_rvalid_out,       // Read done
  input  wire logic                     prom_load_valid_in,   // EEPROM load
  input  wire logic [31:0]              prom_load_data_in,    // Load word
  input  wire logic                     host_phy_program_in,  // Host bit 23
  input  wire logic                     host_phy_enhance_in,  // Host bit 22
  output logic                          host_bits_wr_out,     // Mirror write
  output logic                          host_program_wr_out,  // New bit 23
  output logic                          host_enhance_wr_out,  // New bit 22
  input  wire logic                     link_rate_wr_in,      // Rate write
  input  wire logic [2:0]               link_rate_wdata_in,   // Rate value
  output logic [2:0]                    link_rate_field_out,  // Rate field
  input  wire logic                     cycle_lost_in,        // Lost pulse
  input  wire logic                     cycle_seen_in,        // Start seen
  output logic                          no_cycle_master_out,  // Absent
  input  wire logic                     nand_tree_in,         // Test source
  input  wire logic                     bist_status_in,       // Test source
  output logic                          test_output_pin_out,  // Test pin
  output logic                          bus_holder_en_out,    // Holders on
  output logic                          pm_visible_out,       // PM visible
  output logic                          prom_tick_out,        // EEPROM tick
  output vfc_pkg::phy_feature_type      phy_feature_out       // Results
);

  timeunit 1ns;
  timeprecision 1ps;

  localparam int DIV_W = $clog2(PROM_DIV_NORMAL + 1);

  // Divider ratios the tick logic can serve
  if (PROM_DIV_FAST < 1) begin : g_bad_fast_div
    $error("EEPROM fast divider below one");
  end
  if (PROM_DIV_NORMAL < PROM_DIV_FAST) begin : g_bad_normal_div
    $error("EEPROM normal divider below fast divider");
  end

  function automatic logic combine(input logic [1:0] mode,
                                   input logic enh, input logic modif);
    logic r;
    r = 1'b0;
    case (vfc_pkg::combine_mode_type'(mode))
      vfc_pkg::COMBINE_AND: r = enh & modif;
      vfc_pkg::COMBINE_OR:  r = enh | modif;
      default:              r = enh ^ modif;
    endcase
    return r;
  endfunction

  // Control register
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] wr_mask;
  logic        wr_hit;
  logic        mirror_wr;

  always_comb begin
    wr_mask = {{8{reg_req_in.be[3]}}, {8{reg_req_in.be[2]}},
               {8{reg_req_in.be[1]}}, {8{reg_req_in.be[0]}}};
    wr_hit  = reg_req_in.wr_en && (reg_req_in.addr == vfc_pkg::CTRL_OFFSET);
    ctrl_d  = ctrl_q;
    // EEPROM load wins over a software write in the same cycle
    if (prom_load_valid_in) begin
      ctrl_d = prom_load_data_in & vfc_pkg::CTRL_STORE_MASK;
    end else if (wr_hit) begin
      ctrl_d = (ctrl_q & ~(wr_mask & vfc_pkg::CTRL_STORE_MASK))
             | (reg_req_in.wdata & wr_mask
                & vfc_pkg::CTRL_STORE_MASK);
    end
    mirror_wr = 1'b0;
    if (prom_load_valid_in) begin
      mirror_wr = 1'b1;
    end else if (wr_hit) begin
      mirror_wr = |(wr_mask & vfc_pkg::CTRL_MIRROR_MASK);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_q <= vfc_pkg::CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Mirror bits track the host control register; writes pass through
  logic prog_copy_q;
  logic enh_copy_q;
  logic host_wr_q;
  logic host_prog_q;
  logic host_enh_q;
  logic src_prog;
  logic src_enh;

  // A load outranks a write, so its word feeds the host
  always_comb begin
    src_prog = reg_req_in.wdata[vfc_pkg::PHY_PROGRAM_BIT];
    src_enh  = reg_req_in.wdata[vfc_pkg::PHY_ENHANCE_BIT];
    if (prom_load_valid_in) begin
      src_prog = prom_load_data_in[vfc_pkg::PHY_PROGRAM_BIT];
      src_enh  = prom_load_data_in[vfc_pkg::PHY_ENHANCE_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prog_copy_q <= 1'b0;
      enh_copy_q  <= 1'b0;
      host_wr_q   <= 1'b0;
      host_prog_q <= 1'b0;
      host_enh_q  <= 1'b0;
    end else begin
      prog_copy_q <= host_phy_program_in;
      enh_copy_q  <= host_phy_enhance_in;
      host_wr_q   <= mirror_wr;
      host_prog_q <= src_prog;
      host_enh_q  <= src_enh;
    end
  end

  // Read path, one cycle latency; unmapped offsets read zero
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic        rvalid_d;
  logic        rvalid_q;

  // Data holds between reads; host bits read one cycle late
  always_comb begin
    rvalid_d = reg_req_in.rd_en;
    rdata_d  = rdata_q;
    if (reg_req_in.rd_en) begin
      rdata_d = 32'h0000_0000;
      if (reg_req_in.addr == vfc_pkg::CTRL_OFFSET) begin
        rdata_d = ctrl_q & vfc_pkg::CTRL_STORE_MASK;
        rdata_d[vfc_pkg::PHY_PROGRAM_BIT] = prog_copy_q;
        rdata_d[vfc_pkg::PHY_ENHANCE_BIT] = enh_copy_q;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Link-rate field guarded by the lock bit
  logic [2:0] rate_q;
  logic [2:0] rate_d;

  always_comb begin
    rate_d = rate_q;
    if (link_rate_wr_in && !ctrl_q[vfc_pkg::RATE_LOCK_BIT]) begin
      rate_d = link_rate_wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rate_q <= LINK_RATE_RESET;
    end else begin
      rate_q <= rate_d;
    end
  end

  // Absent-master detector: consecutive lost cycles, saturating
  logic [7:0] lost_q;
  logic [7:0] lost_d;
  logic       absent_q;
  logic       absent_d;

  always_comb begin
    lost_d = lost_q;
    if (ctrl_q[vfc_pkg::DETECTOR_OFF_BIT] || cycle_seen_in) begin
      lost_d = 8'h00;
    end else if (cycle_lost_in && lost_q != vfc_pkg::LOST_LIMIT) begin
      lost_d = lost_q + 8'h01;
    end
    // Force overrides; detector-off then has no effect
    absent_d = ctrl_q[vfc_pkg::FORCE_ABSENT_BIT]
             | (!ctrl_q[vfc_pkg::DETECTOR_OFF_BIT]
                && lost_q == vfc_pkg::LOST_LIMIT);
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lost_q   <= 8'h00;
      absent_q <= 1'b0;
    end else begin
      lost_q   <= lost_d;
      absent_q <= absent_d;
    end
  end

  // EEPROM rate divider; the count carries over when the rate changes
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic [DIV_W-1:0] div_top;
  logic             tick_q;
  logic             tick_d;

  always_comb begin
    div_top = ctrl_q[vfc_pkg::FAST_PROM_BIT]
            ? DIV_W'(PROM_DIV_FAST - 1) : DIV_W'(PROM_DIV_NORMAL - 1);
    tick_d  = 1'b0;
    div_d   = div_q + DIV_W'(1);
    if (div_q >= div_top) begin
      div_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  // Feature enables and pins
  vfc_pkg::phy_feature_type feat_q;
  vfc_pkg::phy_feature_type feat_d;
  logic [1:0] mode;
  logic       test_d;
  logic       test_q;
  logic       holder_q;
  logic       pm_q;

  always_comb begin
    mode = ctrl_q[vfc_pkg::COMBINE_LSB +: 2];
    feat_d.ack_concat  = combine(mode, enh_copy_q,
                                 ctrl_q[vfc_pkg::ACK_CONCAT_BIT]);
    feat_d.ack_accel   = combine(mode, enh_copy_q,
                                 ctrl_q[vfc_pkg::ACK_ACCEL_BIT]);
    feat_d.multirate   = combine(mode, enh_copy_q,
                                 ctrl_q[vfc_pkg::MULTIRATE_BIT]);
    feat_d.idle_insert = combine(mode, enh_copy_q,
                                 ctrl_q[vfc_pkg::IDLE_INSERT_BIT]);
    test_d = ctrl_q[vfc_pkg::TEST_SELECT_BIT]
           ? bist_status_in : nand_tree_in;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      feat_q   <= '0;
      test_q   <= 1'b0;
      holder_q <= 1'b0;
      pm_q     <= 1'b0;
    end else begin
      feat_q   <= feat_d;
      test_q   <= test_d;
      holder_q <= ctrl_q[vfc_pkg::BUS_HOLDER_BIT];
      pm_q     <= ctrl_q[vfc_pkg::PM_VISIBLE_BIT];
    end
  end

  assign reg_rdata_out       = rdata_q;
  assign reg_rvalid_out      = rvalid_q;
  assign host_bits_wr_out    = host_wr_q;
  assign host_program_wr_out = host_prog_q;
  assign host_enhance_wr_out = host_enh_q;
  assign link_rate_field_out = rate_q;
  assign no_cycle_master_out = absent_q;
  assign test_output_pin_out = test_q;
  assign bus_holder_en_out   = holder_q;
  assign pm_visible_out      = pm_q;
  assign prom_tick_out       = tick_q;
  assign phy_feature_out     = feat_q;

endmodule // vendor_feature_control

// ===== src/vfc_pkg.sv
package vfc_pkg;

  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0]  CTRL_OFFSET       = 8'h00;
  localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
  // Bits that hold state; others read as zero, except bits 14 and 13, which read the host copies
  localparam logic [31:0] CTRL_STORE_MASK   = 32'h003F_1EE0;
  localparam logic [31:0] CTRL_MIRROR_MASK  = 32'h0000_6000;

  localparam int BUS_HOLDER_BIT     = 21;
  localparam int PM_VISIBLE_BIT     = 20;
  localparam int TEST_SELECT_BIT    = 19;
  localparam int FAST_PROM_BIT      = 18;
  localparam int COMBINE_LSB        = 16;
  localparam int PHY_PROGRAM_BIT    = 14;
  localparam int PHY_ENHANCE_BIT    = 13;
  localparam int RATE_LOCK_BIT      = 12;
  localparam int DETECTOR_OFF_BIT   = 11;
  localparam int FORCE_ABSENT_BIT   = 10;
  localparam int ACK_CONCAT_BIT     = 9;
  localparam int ACK_ACCEL_BIT      = 7;
  localparam int MULTIRATE_BIT      = 6;
  localparam int IDLE_INSERT_BIT    = 5;

  localparam logic [7:0] LOST_LIMIT = 8'hFF;

  typedef enum logic [1:0] {
    COMBINE_XOR  = 2'b00,
    COMBINE_AND  = 2'b01,
    COMBINE_OR   = 2'b10,
    COMBINE_XOR2 = 2'b11
  } combine_mode_type;

  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic ack_concat;
    logic ack_accel;
    logic multirate;
    logic idle_insert;
  } phy_feature_type;

endpackage
